// [common/fepcs_pkg.sv]
package fepcs_pkg;

  // ==========================================================================
  // Code-groups
  localparam logic [4:0] FEPCS_CG_IDLE = 5'h1F;
  localparam logic [4:0] FEPCS_CG_J = 5'h18;
  localparam logic [4:0] FEPCS_CG_K = 5'h11;
  localparam logic [4:0] FEPCS_CG_T = 5'h0D;
  localparam logic [4:0] FEPCS_CG_R = 5'h07;
  localparam logic [4:0] FEPCS_CG_HALT = 5'h04;

  // ==========================================================================
  // Widths, counts and reset values
  localparam int FEPCS_NIB_W = 4;
  localparam int FEPCS_CG_W = 5;
  localparam int FEPCS_LFSR_W = 11;
  localparam int FEPCS_FIFO_DEPTH = 4;
  localparam logic [2:0] FEPCS_BIT_LAST = 3'h4;
  localparam logic [10:0] FEPCS_SEED_BASE = 11'h5A5;
  localparam logic [4:0] FEPCS_SD_MIN_RUN = 5'h10;

  // ==========================================================================
  // MLT-3 levels
  typedef enum logic [3:0] {
    FEPCS_ML_ZP = 4'b0001,
    FEPCS_ML_POS = 4'b0010,
    FEPCS_ML_ZN = 4'b0100,
    FEPCS_ML_NEG = 4'b1000
  } fepcs_mlt_e;

  // Transmit encoder states
  typedef enum logic [4:0] {
    FEPCS_TX_IDLE = 5'b00001,
    FEPCS_TX_K = 5'b00010,
    FEPCS_TX_DATA = 5'b00100,
    FEPCS_TX_T = 5'b01000,
    FEPCS_TX_R = 5'b10000
  } fepcs_tx_e;

  // MII transmit nibble with its enable and error
  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] nib;
  } fepcs_mii_tx_s;

  // Three-level line symbol from the equalizer
  typedef struct packed {
    logic pos;
    logic neg;
  } fepcs_line_s;

  // ==========================================================================
  // 4B/5B data mapping
  function automatic logic [4:0] fepcs_enc4b5b(input logic [3:0] n);
    logic [4:0] c;
    c = 5'h00;
    case (n)
      4'h0: c = 5'h1E;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0A;
      4'h5: c = 5'h0B;
      4'h6: c = 5'h0E;
      4'h7: c = 5'h0F;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'hA: c = 5'h16;
      4'hB: c = 5'h17;
      4'hC: c = 5'h1A;
      4'hD: c = 5'h1B;
      4'hE: c = 5'h1C;
      default: c = 5'h1D;
    endcase
    return c;
  endfunction

  // x^11 + x^9 + 1 feedback step
  function automatic logic [10:0] fepcs_lfsr_step(input logic [10:0] s);
    return {s[9:0], s[10] ^ s[8]};
  endfunction

endpackage

// [logic/fepcs_fifo.sv]
`timescale 1ns/1ps
module fepcs_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 4
) (
  input wire logic clk_in,            // Clock
  input wire logic rstn_in,           // Async reset, active low
  input wire logic in_valid_in,       // Write request
  output logic in_ready_out,          // Not full
  input wire logic [WIDTH-1:0] in_data_in, // Write data
  output logic out_valid_out,         // Not empty
  input wire logic out_ready_in,      // Read accept
  output logic [WIDTH-1:0] out_data_out // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_out = (cnt_q != DEPTH[AW:0]);
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rd_q];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // fepcs_fifo

// [logic/fepcs_line_coding.sv]
`timescale 1ns/1ps
// Function
// RULE1 - Each MAC nibble becomes a 5-bit code-group.
// RULE2 - First preamble byte is replaced by J then K.
// RULE3 - Remaining preamble and data nibbles map to code-groups.
// RULE4 - Dropping transmit enable appends T then R.
// RULE5 - Idle code-groups follow until transmit enable returns.
// RULE6 - Scrambler is a closed-loop 11-bit LFSR.
// RULE7 - Scrambled bit is LFSR output XOR serial NRZ bit.
// RULE8 - Scrambler seed comes from the five PHY address straps.
// RULE9 - Scrambled serial stream is NRZI encoded.
// RULE10 - MLT-3 split into two drive streams with alternating one events.
// RULE11 - Transmit output is MLT-3 only; no binary output mode.
// RULE12 - Link pulses alone never assert 100 Mb/s signal detect.
// RULE13 - Three-level receive symbols are decoded to NRZI.
// RULE14 - NRZI is decoded to NRZ for the descrambler.
// RULE15 - Receive bits are grouped into 5-bit symbols.
// RULE16 - Receive line stream is turned toward MII nibbles.
// RULE17 - Data nibbles follow the 4B/5B table.
// RULE18 - Idle code-group is all ones.
// RULE19 - NRZI toggles on one, holds on zero; decoder inverts.
// RULE20 - MLT-3 cycles zero, plus, zero, minus on transitions.
module fepcs_line_coding
  import fepcs_pkg::*;
(
  input wire logic ref_clk_in,                    // 125 Mb/s bit clock domain
  input wire logic rstn_in,                       // Async reset, active low
  input wire logic [4:0] phy_address_straps_in,   // PHY address straps
  input wire fepcs_pkg::fepcs_mii_tx_s mii_tx_in, // MII transmit nibble
  input wire logic mii_tx_valid_in,               // Nibble offered
  output logic mii_tx_ready_out,                  // Nibble accepted
  output logic [1:0] line_driver_outputs_out,     // MLT-3 drive pair
  input wire fepcs_pkg::fepcs_line_s rx_line_in,  // Equalizer symbol
  input wire logic rx_energy_in,                  // Energy above threshold
  output logic rx_signal_detect_out,              // 100 Mb/s signal detect
  output logic rx_nrz_out,                        // Serial NRZ to descrambler
  output logic [4:0] rx_symbol_out,               // Deserialized symbol
  output logic rx_symbol_valid_out                // Symbol strobe
);
  import fepcs_pkg::*;

  // ==========================================================================
  // Transmit FIFO
  logic fifo_ready;
  logic fifo_valid;
  logic fifo_pop;
  fepcs_mii_tx_s fifo_word;
  logic [5:0] fifo_out_bits;

  fepcs_fifo #(
    .WIDTH(6),
    .DEPTH(FEPCS_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(mii_tx_valid_in),
    .in_ready_out(fifo_ready),
    .in_data_in(mii_tx_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_out_bits)
  );
  assign fifo_word = fepcs_mii_tx_s'(fifo_out_bits);

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mii_tx_ready_out <= 1'b0;
    end else begin
      mii_tx_ready_out <= fifo_ready;
    end
  end

  // ==========================================================================
  // Code-group encoder
  fepcs_tx_e tx_state_q;
  logic [2:0] bit_cnt_q;
  logic [4:0] shift_q;
  logic first_q;
  logic cg_load;
  logic [4:0] next_cg;
  fepcs_tx_e tx_state_d;
  logic take_nib;

  assign cg_load = (bit_cnt_q == FEPCS_BIT_LAST);

  always_comb begin
    next_cg = FEPCS_CG_IDLE;
    tx_state_d = tx_state_q;
    take_nib = 1'b0;
    case (tx_state_q)
      FEPCS_TX_IDLE: begin
        if (fifo_valid && fifo_word.en) begin
          next_cg = FEPCS_CG_J; // RULE2
          tx_state_d = FEPCS_TX_K;
          take_nib = 1'b1;
        end else begin
          next_cg = FEPCS_CG_IDLE; // RULE5 RULE18
          take_nib = fifo_valid;
        end
      end
      FEPCS_TX_K: begin
        next_cg = FEPCS_CG_K; // RULE2
        tx_state_d = FEPCS_TX_DATA;
        take_nib = fifo_valid;
      end
      FEPCS_TX_DATA: begin
        if (fifo_valid && fifo_word.en) begin
          next_cg = fifo_word.er ? FEPCS_CG_HALT : fepcs_enc4b5b(fifo_word.nib); // RULE1 RULE3 RULE17
          take_nib = 1'b1;
        end else begin
          next_cg = FEPCS_CG_T; // RULE4
          tx_state_d = FEPCS_TX_R;
        end
      end
      FEPCS_TX_T: begin
        next_cg = FEPCS_CG_T; // RULE4
        tx_state_d = FEPCS_TX_R;
      end
      FEPCS_TX_R: begin
        next_cg = FEPCS_CG_R; // RULE4
        tx_state_d = FEPCS_TX_IDLE;
        take_nib = fifo_valid && !fifo_word.en;
      end
      default: begin
        next_cg = FEPCS_CG_IDLE;
        tx_state_d = FEPCS_TX_IDLE;
      end
    endcase
  end

  // The second preamble nibble is swallowed when K is loaded, one code-group after the first
  assign fifo_pop = cg_load && (take_nib || (tx_state_q == FEPCS_TX_K && fifo_valid));

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_state_q <= FEPCS_TX_IDLE;
      bit_cnt_q <= 3'h0;
      shift_q <= FEPCS_CG_IDLE;
    end else if (cg_load) begin
      tx_state_q <= tx_state_d;
      bit_cnt_q <= 3'h0;
      shift_q <= next_cg;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= {shift_q[3:0], 1'b0};
    end
  end

  // ==========================================================================
  // Scrambler, NRZI and MLT-3
  logic [10:0] lfsr_q;
  logic seeded_q;
  logic nrzi_q;
  logic nrzi_prev_q;
  logic scr_bit;
  fepcs_mlt_e mlt_q;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      first_q <= 1'b1;
      seeded_q <= 1'b0;
      lfsr_q <= FEPCS_SEED_BASE;
    end else if (!seeded_q) begin
      seeded_q <= 1'b1;
      lfsr_q <= FEPCS_SEED_BASE ^ {6'h00, phy_address_straps_in}; // RULE8
    end else begin
      first_q <= 1'b0;
      lfsr_q <= fepcs_lfsr_step(lfsr_q); // RULE6
    end
  end

  assign scr_bit = shift_q[4] ^ lfsr_q[10]; // RULE7

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      nrzi_q <= 1'b0;
      nrzi_prev_q <= 1'b0;
    end else begin
      nrzi_prev_q <= nrzi_q;
      if (scr_bit && !first_q) begin
        nrzi_q <= !nrzi_q; // RULE9 RULE19
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mlt_q <= FEPCS_ML_ZP;
    end else if (nrzi_q != nrzi_prev_q) begin
      // Level steps only on an NRZI transition
      case (mlt_q) // RULE20
        FEPCS_ML_ZP: mlt_q <= FEPCS_ML_POS;
        FEPCS_ML_POS: mlt_q <= FEPCS_ML_ZN;
        FEPCS_ML_ZN: mlt_q <= FEPCS_ML_NEG;
        FEPCS_ML_NEG: mlt_q <= FEPCS_ML_ZP;
        default: mlt_q <= FEPCS_ML_ZP;
      endcase
    end
  end

  // Only MLT-3 drive exists; one stream per transformer side
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      line_driver_outputs_out <= 2'b00;
    end else begin
      line_driver_outputs_out <= {mlt_q == FEPCS_ML_NEG, mlt_q == FEPCS_ML_POS}; // RULE10 RULE11
    end
  end

  // ==========================================================================
  // Signal detect
  logic [4:0] sd_run_q;

  // Link pulses are too short to fill the run counter
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sd_run_q <= 5'h00;
      rx_signal_detect_out <= 1'b0;
    end else if (!rx_energy_in) begin
      sd_run_q <= 5'h00;
      rx_signal_detect_out <= 1'b0;
    end else if (sd_run_q != FEPCS_SD_MIN_RUN) begin
      sd_run_q <= sd_run_q + 5'h01;
    end else begin
      rx_signal_detect_out <= 1'b1; // RULE12
    end
  end

  // ==========================================================================
  // Receive decode and deserializer
  logic rx_nrzi_q;
  logic rx_nrzi_prev_q;
  logic [4:0] rx_shift_q;
  logic [2:0] rx_cnt_q;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_nrzi_q <= 1'b0;
      rx_nrzi_prev_q <= 1'b0;
      rx_nrz_out <= 1'b0;
    end else begin
      rx_nrzi_q <= rx_line_in.pos | rx_line_in.neg; // RULE13
      rx_nrzi_prev_q <= rx_nrzi_q;
      rx_nrz_out <= rx_nrzi_q ^ rx_nrzi_prev_q; // RULE14 RULE19
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_shift_q <= 5'h00;
      rx_cnt_q <= 3'h0;
      rx_symbol_out <= 5'h00;
      rx_symbol_valid_out <= 1'b0;
    end else begin
      rx_shift_q <= {rx_shift_q[3:0], rx_nrz_out};
      rx_symbol_valid_out <= 1'b0;
      if (!rx_signal_detect_out) begin
        rx_cnt_q <= 3'h0;
      end else if (rx_cnt_q == FEPCS_BIT_LAST) begin
        rx_cnt_q <= 3'h0;
        rx_symbol_out <= {rx_shift_q[3:0], rx_nrz_out}; // RULE15 RULE16
        rx_symbol_valid_out <= 1'b1;
      end else begin
        rx_cnt_q <= rx_cnt_q + 3'h1;
      end
    end
  end
endmodule // fepcs_line_coding

// [verif/fepcs_line_coding_chk.sv]
`timescale 1ns/1ps
module fepcs_line_coding_chk
  import fepcs_pkg::*;
(
  input wire logic ref_clk_in,                   // Clock
  input wire logic rstn_in,                      // Reset, active low
  input wire logic [1:0] line_driver_outputs_out, // Drive pair
  input wire fepcs_pkg::fepcs_line_s rx_line_in, // Receive symbol
  input wire logic rx_energy_in,                 // Energy
  input wire logic rx_signal_detect_out,         // Signal detect
  input wire logic rx_nrz_out,                   // NRZ bit
  input wire logic rx_symbol_valid_out,          // Symbol strobe
  input wire logic mii_tx_ready_out              // Ready
);
  import fepcs_pkg::*;
  logic [1:0] last_nz_q;
  logic [4:0] run_q;
  // ==========================================================================
  // Helpers
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_nz_q <= 2'h0;
    end else if (line_driver_outputs_out != 2'h0) begin
      last_nz_q <= line_driver_outputs_out;
    end
  end
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      run_q <= 5'h00;
    end else begin
      run_q <= !rx_energy_in ? 5'h00 : (run_q == 5'h1F ? run_q : run_q + 5'h01);
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  property p_no_both; line_driver_outputs_out != 2'h3; endproperty
  a_no_both: assert property (p_no_both) else $error("both sides driven");
  property p_step;
    line_driver_outputs_out != $past(line_driver_outputs_out) && $past(line_driver_outputs_out)
      != 2'h0 |-> line_driver_outputs_out == 2'h0;
  endproperty
  a_step: assert property (p_step) else $error("level skipped zero");
  property p_alt;
    line_driver_outputs_out != 2'h0 && $past(line_driver_outputs_out) == 2'h0 |->
      line_driver_outputs_out != last_nz_q && (last_nz_q != 2'h0 || line_driver_outputs_out == 2'h1);
  endproperty
  a_alt: assert property (p_alt) else $error("sides not alternating");
  property p_sd_run; $rose(rx_signal_detect_out) |-> run_q >= 5'h11; endproperty
  a_sd_run: assert property (p_sd_run) else $error("detect too early");
  property p_sd_drop; !rx_energy_in [*3] |-> !rx_signal_detect_out; endproperty
  a_sd_drop: assert property (p_sd_drop) else $error("detect without energy");
  property p_sym_gap; rx_symbol_valid_out |=> !rx_symbol_valid_out [*4]; endproperty
  a_sym_gap: assert property (p_sym_gap) else $error("symbol spacing");
  property p_sym_sd;
    rx_symbol_valid_out |-> rx_signal_detect_out || $past(rx_signal_detect_out);
  endproperty
  a_sym_sd: assert property (p_sym_sd) else $error("symbol without detect");
  property p_rx_nrz;
    rx_nrz_out == ($past(rx_line_in.pos | rx_line_in.neg, 2) ^
      $past(rx_line_in.pos | rx_line_in.neg, 3));
  endproperty
  a_rx_nrz: assert property (p_rx_nrz) else $error("nrz decode");
  c_sd: cover property ($rose(rx_signal_detect_out));
  c_sym: cover property (rx_symbol_valid_out);
  c_full: cover property (!mii_tx_ready_out);
endmodule // fepcs_line_coding_chk

bind fepcs_line_coding fepcs_line_coding_chk u_chk (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .line_driver_outputs_out(line_driver_outputs_out),
  .rx_line_in(rx_line_in), .rx_energy_in(rx_energy_in), .rx_nrz_out(rx_nrz_out),
  .rx_signal_detect_out(rx_signal_detect_out), .rx_symbol_valid_out(rx_symbol_valid_out),
  .mii_tx_ready_out(mii_tx_ready_out));

// [verif/fepcs_mac_model.sv]
`timescale 1ns/1ps
module fepcs_mac_model
  import fepcs_pkg::*;
(
  input wire logic clk_in,                 // Clock
  input wire logic ready_in,               // Word accepted
  output fepcs_pkg::fepcs_mii_tx_s tx_out, // Word
  output logic valid_out                   // Word offered
);
  import fepcs_pkg::*;
  initial begin
    tx_out = '0;
    valid_out = 1'b0;
  end
  // Ready is one cycle stale, so a gap of two keeps offers safe
  task automatic send(input fepcs_mii_tx_s w[$], input int gap, output bit ok);
    int t;
    ok = 1'b1;
    foreach (w[i]) begin
      tx_out <= w[i];
      valid_out <= 1'b1;
      t = 0;
      do begin
        @(posedge clk_in);
        t++;
      end while (ready_in !== 1'b1 && t < 200);
      if (t >= 200) ok = 1'b0;
      valid_out <= 1'b0;
      tx_out <= ~w[i];
      repeat (gap) @(posedge clk_in);
    end
  endtask
endmodule // fepcs_mac_model

// [verif/tb_fepcs_line_coding.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_fepcs_line_coding;
  import fepcs_pkg::*;
  localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic ref_clk_in, rstn_in, mii_tx_valid_in, mii_tx_ready_out, rx_energy_in, in_fr;
  logic rx_signal_detect_out, rx_nrz_out, rx_symbol_valid_out;
  logic [4:0] phy_address_straps_in, rx_symbol_out, m;
  logic [3:0] lv;
  logic [1:0] line_driver_outputs_out, ln;
  logic [10:0] ks;
  logic [9:0] sr;
  logic [4:0] want[$];
  fepcs_mii_tx_s mii_tx_in;
  fepcs_line_s rx_line_in;
  int n_mismatch = 0, num_checks = 0, warm, cnt, t, nsym, r;
  integer seed = 32'h426D;
  fepcs_line_coding dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .phy_address_straps_in(phy_address_straps_in), .mii_tx_in(mii_tx_in),
    .mii_tx_valid_in(mii_tx_valid_in), .mii_tx_ready_out(mii_tx_ready_out),
    .line_driver_outputs_out(line_driver_outputs_out), .rx_line_in(rx_line_in),
    .rx_energy_in(rx_energy_in), .rx_signal_detect_out(rx_signal_detect_out),
    .rx_nrz_out(rx_nrz_out), .rx_symbol_out(rx_symbol_out),
    .rx_symbol_valid_out(rx_symbol_valid_out));
  fepcs_mac_model mac (.clk_in(ref_clk_in), .ready_in(mii_tx_ready_out), .tx_out(mii_tx_in),
    .valid_out(mii_tx_valid_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  // ==========================================================================
  // Line monitor: learns the keystream from idles, then descrambles
  always @(posedge ref_clk_in) begin : mon
    logic s, p, kp;
    logic [4:0] e;
    if (!rstn_in) begin
      warm = 0;
      ln = 2'h0;
      in_fr = 1'b0;
    end else begin
      s = (line_driver_outputs_out !== ln);
      ln = line_driver_outputs_out;
      kp = ks[10] ^ ks[8];
      p = s ^ kp;
      if (warm < 31) begin
        warm++;
        kp = ~s;
      end
      ks = {ks[9:0], kp};
      sr = {sr[8:0], p};
      if (in_fr) cnt++;
      if ((warm == 31 && !in_fr && sr == 10'h3F8) || (in_fr && cnt == 5)) begin
        cnt = 0;
        e = want.size() > 0 ? want.pop_front() : 5'h00;
        `CHK(sr[4:0], e)
        in_fr = want.size() > 0;
      end
    end
  end
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic frame(input int n, input bit walk, input int gap);
    fepcs_mii_tx_s q[$];
    fepcs_mii_tx_s w;
    bit ok;
    int i;
    for (i = 0; i < n; i++) begin
      w.en = 1'b1;
      w.er = walk && i == 20;
      w.nib = (walk && i < 18) ? 4'(i - 2) : 4'($random(seed));
      if (i < 2) w.nib = 4'h5;
      q.push_back(w);
      want.push_back(i == 0 ? FEPCS_CG_J : i == 1 ? FEPCS_CG_K :
        w.er ? FEPCS_CG_HALT : ENC[w.nib]);
    end
    w = '0;
    w.nib = 4'($random(seed));
    q.push_back(w);
    want.push_back(FEPCS_CG_T);
    want.push_back(FEPCS_CG_R);
    want.push_back(FEPCS_CG_IDLE);
    @(posedge ref_clk_in);
    mac.send(q, gap, ok);
    `CHK(ok, 1'b1)
    for (i = 0; i < 3000 && want.size() > 0; i++) @(posedge ref_clk_in);
    `CHK(want.size(), 0)
    if (!ok || want.size() > 0) final_report();
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    rstn_in = 1'b0;
    rx_energy_in = 1'b0;
    rx_line_in = '0;
    phy_address_straps_in = 5'($random(seed));
    repeat (4) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    repeat (40) @(posedge ref_clk_in);
    `CHK(mii_tx_ready_out, 1'b1)
    frame(26, 1'b1, 2);
    repeat (4) frame(3 + ($random(seed) & 7), 1'b0, 2 + ($random(seed) & 1));
    repeat (3) begin
      rx_energy_in <= 1'b1;
      repeat (8) @(posedge ref_clk_in);
      `CHK(rx_signal_detect_out, 1'b0)
      rx_energy_in <= 1'b0;
      repeat (8) @(posedge ref_clk_in);
    end
    rx_energy_in <= 1'b1;
    nsym = 0;
    lv = 4'h0;
    m = 5'h00;
    // Model: level = pos or neg, NRZ = level xor previous, symbol = last five NRZ bits
    for (t = 0; t < 80; t++) begin
      r = $random(seed);
      rx_line_in.pos <= r[0];
      rx_line_in.neg <= r[1] & !r[0];
      @(posedge ref_clk_in);
      lv = {lv[2:0], r[0] | r[1]};
      `CHK(rx_nrz_out, lv[2] ^ lv[3])
      if (rx_symbol_valid_out === 1'b1) `CHK(rx_symbol_out, m)
      m = {m[3:0], lv[2] ^ lv[3]};
      if (t >= 30 && rx_symbol_valid_out === 1'b1) nsym++;
    end
    `CHK(rx_signal_detect_out, 1'b1)
    `CHK(nsym, 10)
    final_report();
  end
endmodule // tb_fepcs_line_coding
